/* ccp_consts.svh */
// Constants for the system clock and power mode controller
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH
`define CCP_ADDR_SYS_CTRL 12'h000
`define CCP_ADDR_OSC_CTRL 12'h004
`define CCP_ADDR_INT_STAT 12'h008
`define CCP_ADDR_INT_MASK 12'h00C
`define CCP_ADDR_MODE 12'h010
`define CCP_SYS_SEL_LSB 5
`define CCP_SYS_HS_IDLE_BIT 1
`define CCP_SYS_LS_IDLE_BIT 0
`define CCP_OSC_FREQ_LSB 2
`define CCP_OSC_STABLE_BIT 1
`define CCP_OSC_EN_BIT 0
`define CCP_SEL_SLOW 3'h7
`define CCP_SYS_RESET 8'h00
`define CCP_FREQ_RESET 2'h0
`define CCP_HS_EN_RESET 1'b1
`define CCP_INT_W 3
`define CCP_INT_HS_STABLE 0
`define CCP_INT_HALT 1
`define CCP_INT_WAKE 2
`define CCP_CLK_NS 25
`define CCP_HS_SETTLE_NS 16000
`define CCP_HS_SETTLE_CYC ((`CCP_HS_SETTLE_NS + `CCP_CLK_NS - 1) / `CCP_CLK_NS)
`endif

/* ccp_pkg.sv */
// Types for the system clock and power mode controller
package ccp_pkg;
  typedef enum logic [2:0] {
    CCP_FAST,
    CCP_SLOW,
    CCP_SLEEP,
    CCP_IDLE_LOW,
    CCP_IDLE_BOTH,
    CCP_IDLE_HIGH
  } ccp_mode_e;
  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_tick;
    logic high_clk_run;
    logic low_clk_run;
    logic hs_osc_run;
    logic ls_osc_run;
    logic [1:0] hs_osc_freq;
  } ccp_clk_s;
endpackage

/* ccp_clock_ctrl.sv */
// System clock selection, fast oscillator control and halt modes
`timescale 1ns/10ps
`default_nettype none
`include "ccp_consts.svh"
module ccp_clock_ctrl import ccp_pkg::*; #(
  parameter int HS_SETTLE_CYC = `CCP_HS_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic ls_osc_ready,
  input wire logic ls_clk_in,
  output var ccp_clk_s clk_out,
  output var ccp_mode_e mode,
  output logic irq
);

  // ==========================================================
  // Functions
  function automatic logic is_slow(input logic [2:0] sel);
    is_slow = (sel == `CCP_SEL_SLOW);
  endfunction

  function automatic logic [5:0] div_mask(input logic [2:0] sel);
    div_mask = 6'(7'h01 << sel) - 6'h01;
  endfunction

  // ==========================================================
  // Declarations
  logic [2:0] sel_reg;
  logic [2:0] sel_act_reg;
  logic hs_idle_reg;
  logic ls_idle_reg;
  logic [1:0] freq_reg;
  logic [1:0] freq_act_reg;
  logic hs_en_reg;
  logic hs_stable_reg;
  logic [31:0] settle_reg;
  logic restart;
  logic halted_reg;
  ccp_mode_e mode_reg;
  logic [`CCP_INT_W-1:0] int_stat_reg;
  logic [`CCP_INT_W-1:0] int_stat_next;
  logic [`CCP_INT_W-1:0] int_mask_reg;
  logic [`CCP_INT_W-1:0] int_set;
  logic [1:0] ls_rdy_sync_reg;
  logic [2:0] ls_clk_sync_reg;
  logic ls_tick;
  logic [5:0] div_cnt_reg;
  logic hs_run;
  logic low_run;
  logic high_run;
  logic sys_run;
  logic tick;
  logic wr_en;
  logic rd_en;
  logic wr_sys;
  logic wr_osc;
  logic [2:0] new_sel;
  logic [1:0] new_freq;
  logic new_en;
  logic [31:0] rd_mux;
  logic addr_ok;

  // ==========================================================
  // Bus decode
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign wr_sys = wr_en & (paddr == `CCP_ADDR_SYS_CTRL);
  assign wr_osc = wr_en & (paddr == `CCP_ADDR_OSC_CTRL);
  assign pready = 1'b1;
  assign new_sel = pwdata[`CCP_SYS_SEL_LSB+:3];
  assign new_freq = pwdata[`CCP_OSC_FREQ_LSB+:2];
  assign new_en = pwdata[`CCP_OSC_EN_BIT];

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CCP_ADDR_SYS_CTRL: begin
        rd_mux[`CCP_SYS_SEL_LSB+:3] = sel_reg;
        rd_mux[`CCP_SYS_HS_IDLE_BIT] = hs_idle_reg;
        rd_mux[`CCP_SYS_LS_IDLE_BIT] = ls_idle_reg;
      end
      `CCP_ADDR_OSC_CTRL: begin
        rd_mux[`CCP_OSC_FREQ_LSB+:2] = freq_reg;
        rd_mux[`CCP_OSC_STABLE_BIT] = hs_stable_reg;
        rd_mux[`CCP_OSC_EN_BIT] = hs_en_reg;
      end
      `CCP_ADDR_INT_STAT: begin
        rd_mux[`CCP_INT_W-1:0] = int_stat_reg;
      end
      `CCP_ADDR_INT_MASK: begin
        rd_mux[`CCP_INT_W-1:0] = int_mask_reg;
      end
      `CCP_ADDR_MODE: begin
        rd_mux[2:0] = 3'(mode_reg);
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================
  // System clock control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= 3'h0;
      hs_idle_reg <= 1'b0;
      ls_idle_reg <= 1'b0;
    end else if (wr_sys) begin
      sel_reg <= new_sel;
      hs_idle_reg <= pwdata[`CCP_SYS_HS_IDLE_BIT];
      ls_idle_reg <= pwdata[`CCP_SYS_LS_IDLE_BIT];
    end
  end

  // ==========================================================
  // Fast oscillator control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_reg <= `CCP_FREQ_RESET;
      hs_en_reg <= `CCP_HS_EN_RESET;
    end else if (wr_osc) begin
      freq_reg <= new_freq;
      hs_en_reg <= new_en;
    end
  end

  // Restart settling on enable rise or frequency change
  assign restart = wr_osc & ((new_en & ~hs_en_reg) | (new_freq != freq_reg));

  // ==========================================================
  // Fast oscillator settling and stable flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 32'h0000_0000;
      hs_stable_reg <= 1'b0;
    end else if (restart || !hs_run) begin
      settle_reg <= 32'h0000_0000;
      hs_stable_reg <= 1'b0;
    end else if (settle_reg >= 32'(HS_SETTLE_CYC - 1)) begin
      hs_stable_reg <= 1'b1;
    end else begin
      settle_reg <= settle_reg + 32'h0000_0001;
    end
  end

  // Applied frequency follows the request only once stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_act_reg <= `CCP_FREQ_RESET;
    end else if (hs_stable_reg) begin
      freq_act_reg <= freq_reg;
    end
  end

  // ==========================================================
  // Slow oscillator status and clock synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_rdy_sync_reg <= 2'h0;
      ls_clk_sync_reg <= 3'h0;
    end else begin
      ls_rdy_sync_reg <= {ls_rdy_sync_reg[0], ls_osc_ready};
      ls_clk_sync_reg <= {ls_clk_sync_reg[1:0], ls_clk_in};
    end
  end

  assign ls_tick = ls_clk_sync_reg[1] & ~ls_clk_sync_reg[2];

  // ==========================================================
  // Applied clock selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_act_reg <= 3'h0;
    end else if (is_slow(sel_reg)) begin
      if (ls_rdy_sync_reg[1]) begin
        sel_act_reg <= sel_reg;
      end
    end else if (hs_stable_reg) begin
      sel_act_reg <= sel_reg;
    end
  end

  // ==========================================================
  // Operating mode state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= CCP_FAST;
      halted_reg <= 1'b0;
    end else begin
      case (mode_reg)
        CCP_FAST, CCP_SLOW: begin
          halted_reg <= 1'b0;
          if (halt_req) begin
            halted_reg <= 1'b1;
            case ({hs_idle_reg, ls_idle_reg})
              2'b00: mode_reg <= CCP_SLEEP;
              2'b01: mode_reg <= CCP_IDLE_LOW;
              2'b11: mode_reg <= CCP_IDLE_BOTH;
              default: mode_reg <= CCP_IDLE_HIGH;
            endcase
          end else if (is_slow(sel_act_reg)) begin
            mode_reg <= CCP_SLOW;
          end else begin
            mode_reg <= CCP_FAST;
          end
        end
        CCP_SLEEP, CCP_IDLE_LOW, CCP_IDLE_BOTH, CCP_IDLE_HIGH: begin
          if (wake_req) begin
            halted_reg <= 1'b0;
            mode_reg <= is_slow(sel_act_reg) ? CCP_SLOW : CCP_FAST;
          end
        end
        default: begin
          mode_reg <= CCP_FAST;
          halted_reg <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Oscillator and clock feed gating
  always_comb begin
    hs_run = hs_en_reg;
    low_run = 1'b1;
    case (mode_reg)
      CCP_SLEEP: begin
        hs_run = 1'b0;
        low_run = 1'b0;
      end
      CCP_IDLE_LOW: begin
        hs_run = 1'b0;
      end
      CCP_IDLE_BOTH: begin
        hs_run = 1'b1;
      end
      CCP_IDLE_HIGH: begin
        hs_run = 1'b1;
        low_run = 1'b0;
      end
      default: begin
        // Forced on while a fast selection is requested or applied
        hs_run = hs_en_reg | ~is_slow(sel_reg) | ~is_slow(sel_act_reg);
      end
    endcase
  end

  assign high_run = hs_run & hs_stable_reg;
  assign sys_run = is_slow(sel_act_reg) ? (low_run | ~halted_reg) : high_run;

  // ==========================================================
  // High clock divider and system clock tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 6'h00;
    end else if (high_run) begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  always_comb begin
    if (is_slow(sel_act_reg)) begin
      tick = ls_tick & sys_run;
    end else begin
      tick = sys_run & ((div_cnt_reg & div_mask(sel_act_reg)) == 6'h00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out <= '0;
    end else begin
      clk_out.cpu_clk_en <= ~halted_reg & ~halt_req;
      clk_out.sys_clk_tick <= tick;
      clk_out.high_clk_run <= high_run;
      clk_out.low_clk_run <= low_run;
      clk_out.hs_osc_run <= hs_run;
      clk_out.ls_osc_run <= 1'b1;
      clk_out.hs_osc_freq <= freq_act_reg;
    end
  end

  assign mode = mode_reg;

  // ==========================================================
  // Interrupt status and mask
  assign int_set[`CCP_INT_HS_STABLE] = hs_run & ~hs_stable_reg &
    (settle_reg >= 32'(HS_SETTLE_CYC - 1)) & ~restart;
  assign int_set[`CCP_INT_HALT] = halt_req & ~halted_reg;
  assign int_set[`CCP_INT_WAKE] = wake_req & halted_reg;

  always_comb begin
    int_stat_next = int_stat_reg;
    if (wr_en && paddr == `CCP_ADDR_INT_STAT) begin
      int_stat_next = int_stat_reg & ~pwdata[`CCP_INT_W-1:0];
    end
    int_stat_next = int_stat_next | int_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= int_stat_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_reg <= '0;
    end else if (wr_en && paddr == `CCP_ADDR_INT_MASK) begin
      int_mask_reg <= pwdata[`CCP_INT_W-1:0];
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);

endmodule
`default_nettype wire

/* ccp_clock_ctrl_properties.sv */
// Concurrent checks on the clock and power mode controller ports
`timescale 1ns/10ps
`default_nettype none
module ccp_clock_props import ccp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic halt_req,
  input wire ccp_clk_s clk_out,
  input wire ccp_mode_e mode
);
  // ==========
  // Helpers
  logic [1:0] up_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence halt_taken;
    (mode == CCP_FAST || mode == CCP_SLOW) && halt_req;
  endsequence
  sequence cpu_off_late;
    1'b1 ##1 !clk_out.cpu_clk_en;
  endsequence
  // ==========
  // Assertions
  a_halt_cpu_off: assert property (halt_taken |=> cpu_off_late)
    else $error("cpu clock still on after halt");
  a_halt_enters: assert property (halt_taken |=> mode != CCP_FAST && mode != CCP_SLOW)
    else $error("halt did not leave run modes");
  a_run_stays: assert property ((mode == CCP_FAST || mode == CCP_SLOW) && !halt_req
    |=> mode == CCP_FAST || mode == CCP_SLOW) else $error("left run modes without halt");
  a_slow_osc_on: assert property (up_cnt == 2'h3 |-> clk_out.ls_osc_run)
    else $error("slow oscillator stopped");
  a_sleep_feeds: assert property (mode == CCP_SLEEP && $past(mode) == CCP_SLEEP
    |-> !clk_out.high_clk_run && !clk_out.low_clk_run) else $error("feed on in sleep");
  a_idle_low_feeds: assert property (mode == CCP_IDLE_LOW && $past(mode) == CCP_IDLE_LOW
    |-> !clk_out.high_clk_run && clk_out.low_clk_run) else $error("bad feeds in idle low mode");
  a_idle_both_feeds: assert property (mode == CCP_IDLE_BOTH && $past(mode) == CCP_IDLE_BOTH
    |-> clk_out.high_clk_run && clk_out.low_clk_run) else $error("bad feeds in idle both mode");
  a_idle_high_feeds: assert property (mode == CCP_IDLE_HIGH && $past(mode) == CCP_IDLE_HIGH
    |-> clk_out.high_clk_run && !clk_out.low_clk_run) else $error("bad feeds in idle high mode");
  a_sleep_no_tick: assert property (mode == CCP_SLEEP && $past(mode) == CCP_SLEEP
    |-> !clk_out.sys_clk_tick) else $error("system clock ticks in sleep");
endmodule
bind ccp_clock_ctrl ccp_clock_props ccp_clock_props_i (.pclk(pclk), .presetn(presetn),
  .halt_req(halt_req), .clk_out(clk_out), .mode(mode));
`default_nettype wire

/* ccp_tb.sv */
// Self-checking testbench for the clock and power mode controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb import ccp_pkg::*;;
  // ==========
  // Signals
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic halt_req = 0;
  logic wake_req = 0;
  logic ls_osc_ready = 0;
  logic ls_clk_in = 0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  ccp_clk_s clk_out;
  ccp_mode_e mode;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_compared = 0;
  ccp_clock_ctrl #(.HS_SETTLE_CYC(8)) ccp_clock_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
    .wake_req(wake_req), .ls_osc_ready(ls_osc_ready), .ls_clk_in(ls_clk_in),
    .clk_out(clk_out), .mode(mode), .irq(irq));
  // ==========
  // Clocks and watchdog
  initial forever #12.5 pclk = ~pclk;
  always begin
    repeat (8) @(posedge pclk);
    ls_clk_in <= ~ls_clk_in;
  end
  initial begin
    #500000;
    n_errors++;
    wrap_up();
  end
  // ==========
  // Bus and pulse tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  task automatic pulse(input logic wake);
    halt_req <= !wake;
    wake_req <= wake;
    @(posedge pclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic wrap_up();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    rdc(12'h004, 32'h0000_0001);
    rdc(12'h000, 32'h0000_0000);
    repeat (12) @(posedge pclk);
    rdc(12'h004, 32'h0000_0003);
    wr(12'h000, 32'hffff_ffff);
    rdc(12'h000, 32'h0000_00e3);
    `CHK(mode, CCP_FAST)
    wr(12'h000, 32'h0000_0000);
    wr(12'h004, 32'hffff_fff9);
    rdc(12'h004, 32'h0000_0009);
    `CHK(clk_out.hs_osc_freq, 2'h0)
    repeat (12) @(posedge pclk);
    rdc(12'h004, 32'h0000_000b);
    `CHK(clk_out.hs_osc_freq, 2'h2)
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
  endtask
  task automatic t_div();
    int n;
    for (int c = 0; c < 8; c++) begin
      if (c == 7) ls_osc_ready <= 1'b1;
      wr(12'h000, 32'(c) << 5);
      repeat (40) @(posedge pclk);
      n = 0;
      while (clk_out.sys_clk_tick !== 1'b1 && n < 200) begin
        @(posedge pclk);
        n++;
      end
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (clk_out.sys_clk_tick !== 1'b1 && n < 200);
      `CHK(n, c == 7 ? 16 : 1 << c)
    end
    `CHK(mode, CCP_SLOW)
    wr(12'h004, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    `CHK(clk_out.hs_osc_run, 1'b0)
    wr(12'h004, 32'h0000_0001);
    repeat (12) @(posedge pclk);
    `CHK(clk_out.hs_osc_run, 1'b1)
    rdc(12'h004, 32'h0000_0003);
    wr(12'h000, 32'h0000_0000);
  endtask
  task automatic t_halt();
    ccp_mode_e m[4] = '{CCP_SLEEP, CCP_IDLE_LOW, CCP_IDLE_HIGH, CCP_IDLE_BOTH};
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, 32'(i));
      `CHK(mode, CCP_FAST)
      pulse(1'b0);
      `CHK(mode, m[i])
      `CHK({clk_out.high_clk_run, clk_out.low_clk_run}, 2'(i))
      `CHK({clk_out.cpu_clk_en, clk_out.ls_osc_run}, 2'h1)
      `CHK(clk_out.sys_clk_tick, 1'(i >> 1))
      pulse(1'b1);
      `CHK(clk_out.cpu_clk_en, 1'b1)
      repeat (12) @(posedge pclk);
    end
  endtask
  task automatic t_irq();
    wr(12'h00c, 32'h0000_0000);
    wr(12'h008, 32'h0000_0007);
    wr(12'h00c, 32'h0000_0002);
    `CHK(irq, 1'b0)
    wr(12'h000, 32'h0000_0003);
    pulse(1'b0);
    `CHK(irq, 1'b1)
    wr(12'h00c, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(12'h00c, 32'h0000_0002);
    wr(12'h008, 32'h0000_0002);
    `CHK(irq, 1'b0)
    pulse(1'b1);
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_div();
    t_halt();
    t_irq();
    wrap_up();
  end
endmodule
`default_nettype wire
